/* otpcfg_pkg.sv */
// package: constants and carrier types of the otp configuration and security block
package otpcfg_pkg;

  localparam logic [15:0] SIG_ADDR_0 = 16'hFC30;
  localparam logic [15:0] SIG_ADDR_1 = 16'hFC31;
  localparam logic [15:0] SIG_ADDR_2 = 16'hFC60;
  localparam logic [15:0] CUST_BASE = 16'hFCE0;
  localparam logic [15:0] CUST_LAST = 16'hFCFF;
  localparam logic [15:0] CFG1_ADDR = 16'hFD00;
  localparam logic [15:0] CFG2_ADDR = 16'hFD01;
  localparam logic [15:0] CODE_SIZE = 16'h1000;

  localparam logic [7:0] UNPROG_BYTE = 8'hFF;
  localparam logic [7:0] REFUSED_BYTE = 8'h00;

  // field positions in config byte one
  localparam int WDOG_POS = 7;
  localparam int RSTPIN_POS = 6;
  localparam int PRL_POS = 5;
  localparam int BOV_POS = 4;
  localparam int CDIV_POS = 3;
  localparam int OSC_MSB = 2;
  localparam int OSC_LSB = 0;
  localparam logic [2:0] OSC_EXT_CLOCK = 3'h7;

  // serial frame: command byte, address word, data byte, msb first
  localparam int FRAME_BITS = 32;
  localparam int REPLY_BITS = 8;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] CMD_LOCK = 8'h03;

  typedef struct packed {
    logic rd;
    logic fetch;
    logic [15:0] addr;
  } otpcfg_req_t;

  typedef struct packed {
    logic watchdog_fuse;
    logic reset_pin_fuse;
    logic port_reset_level;
    logic brownout_level_fuse;
    logic cycle_divider_fuse;
    logic [2:0] osc_select_field;
    logic [7:0] config_byte_two;
  } otpcfg_applied_t;

  typedef struct packed {
    logic lock_bit_two;
    logic lock_bit_one;
  } otpcfg_lock_t;

endpackage : otpcfg_pkg

/* otpcfg_top.sv */
// module: otp signature, customer area, config bytes, lock bits and serial programming engine
module otpcfg_top
  import otpcfg_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE_0 = 8'h15, // arbitrary value
  parameter logic [7:0] SIG_BYTE_1 = 8'h2A, // arbitrary value
  parameter logic [7:0] SIG_BYTE_2 = 8'h3C  // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic prog_mode_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  output logic ser_data_o,
  output logic ser_data_oe_o,
  input wire otpcfg_req_t code_req_i,
  input wire otpcfg_req_t xdata_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic code_wr_o,
  output logic [15:0] code_addr_o,
  output logic [7:0] code_wdata_o,
  input wire logic [7:0] code_rdata_i,
  output logic prog_allowed_o,
  output logic verify_allowed_o,
  output logic cfg_valid_o,
  output otpcfg_applied_t applied_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] pm_sync_ff, sck_sync_ff, sdi_sync_ff;
  logic sck_prev_ff;
  logic [1:0] nxt_pm_sync, nxt_sck_sync, nxt_sdi_sync;
  logic nxt_sck_prev;
  logic sck_rise;

  always_comb begin
    nxt_pm_sync = {pm_sync_ff[0], prog_mode_i};
    nxt_sck_sync = {sck_sync_ff[0], ser_clk_i};
    nxt_sdi_sync = {sdi_sync_ff[0], ser_data_i};
    nxt_sck_prev = sck_sync_ff[1];
    sck_rise = sck_sync_ff[1] & ~sck_prev_ff;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pm_sync_ff <= 2'h0;
      sck_sync_ff <= 2'h0;
      sdi_sync_ff <= 2'h0;
      sck_prev_ff <= 1'b0;
    end else begin
      pm_sync_ff <= nxt_pm_sync;
      sck_sync_ff <= nxt_sck_sync;
      sdi_sync_ff <= nxt_sdi_sync;
      sck_prev_ff <= nxt_sck_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // otp contents; held in flops here, erased state is all ones
  logic [31:0][7:0] cust_ff, nxt_cust;
  logic [7:0] cfg1_ff, cfg2_ff, nxt_cfg1, nxt_cfg2;
  otpcfg_lock_t lock_ff, nxt_lock;

  function automatic logic in_cust(input logic [15:0] a);
    in_cust = (a >= CUST_BASE) && (a <= CUST_LAST);
  endfunction : in_cust

  // shared read decode for cpu and programmer
  function automatic logic [7:0] otp_read(input logic [15:0] a, input logic [31:0][7:0] cu,
                                          input logic [7:0] c1, input logic [7:0] c2);
    otp_read = UNPROG_BYTE;
    if (a == SIG_ADDR_0) otp_read = SIG_BYTE_0;
    else if (a == SIG_ADDR_1) otp_read = SIG_BYTE_1;
    else if (a == SIG_ADDR_2) otp_read = SIG_BYTE_2;
    else if (in_cust(a)) otp_read = cu[a[4:0]];
    else if (a == CFG1_ADDR) otp_read = c1;
    else if (a == CFG2_ADDR) otp_read = c2;
  endfunction : otp_read

  ////////////////////////////////////////////////////////////////////////////
  // serial programming engine
  typedef enum logic [1:0] {S_SHIFT, S_EXEC, S_VERIFY, S_REPLY} otpcfg_state_t;
  otpcfg_state_t st_ff, nxt_st;
  logic [31:0] sh_ff, nxt_sh;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [7:0] rep_ff, nxt_rep;
  logic sdo_ff, sdo_oe_ff, nxt_sdo, nxt_sdo_oe;
  logic cwr_ff, nxt_cwr;
  logic [15:0] caddr_ff, nxt_caddr;
  logic [7:0] cwd_ff, nxt_cwd;
  logic prog_ok, verify_ok;
  logic [7:0] f_cmd, f_dat;
  logic [15:0] f_adr;

  always_comb begin
    prog_ok = lock_ff.lock_bit_one;
    verify_ok = lock_ff.lock_bit_one | lock_ff.lock_bit_two;
    f_cmd = sh_ff[31:24];
    f_adr = sh_ff[23:8];
    f_dat = sh_ff[7:0];
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_cnt = cnt_ff;
    nxt_rep = rep_ff;
    nxt_sdo = sdo_ff;
    nxt_sdo_oe = sdo_oe_ff;
    nxt_cwr = 1'b0;
    nxt_caddr = caddr_ff;
    nxt_cwd = cwd_ff;
    nxt_cust = cust_ff;
    nxt_cfg1 = cfg1_ff;
    nxt_cfg2 = cfg2_ff;
    nxt_lock = lock_ff;
    if (!pm_sync_ff[1]) begin
      // leaving programming mode aborts any frame in flight
      nxt_st = S_SHIFT;
      nxt_cnt = 6'h0;
      nxt_sdo_oe = 1'b0;
    end else begin
      case (st_ff)
        S_SHIFT: begin
          if (sck_rise) begin
            nxt_sh = {sh_ff[30:0], sdi_sync_ff[1]};
            nxt_cnt = cnt_ff + 6'h1;
            if (cnt_ff == 6'(FRAME_BITS - 1)) begin
              nxt_st = S_EXEC;
            end
          end
        end
        S_EXEC: begin
          nxt_cnt = 6'h0;
          nxt_st = S_SHIFT;
          if (f_cmd == CMD_WRITE && prog_ok) begin
            // programming only clears bits of otp flops; code array writes pass f_dat unchanged
            if (in_cust(f_adr)) nxt_cust[f_adr[4:0]] = cust_ff[f_adr[4:0]] & f_dat;
            else if (f_adr == CFG1_ADDR) nxt_cfg1 = cfg1_ff & f_dat;
            else if (f_adr == CFG2_ADDR) nxt_cfg2 = cfg2_ff & f_dat;
            else if (f_adr < CODE_SIZE) begin
              nxt_cwr = 1'b1;
              nxt_caddr = f_adr;
              nxt_cwd = f_dat;
            end
          end else if (f_cmd == CMD_LOCK) begin
            // lock two stays programmable after lock one
            nxt_lock.lock_bit_one = lock_ff.lock_bit_one & f_dat[0];
            nxt_lock.lock_bit_two = lock_ff.lock_bit_two & f_dat[1];
          end else if (f_cmd == CMD_READ) begin
            nxt_caddr = f_adr;
            nxt_st = S_VERIFY;
          end
        end
        S_VERIFY: begin
          // code array answers in the same cycle the address is presented on code_addr_o
          if (!verify_ok) nxt_rep = REFUSED_BYTE;
          else if (caddr_ff < CODE_SIZE) nxt_rep = code_rdata_i;
          else nxt_rep = otp_read(caddr_ff, cust_ff, cfg1_ff, cfg2_ff);
          nxt_sdo = nxt_rep[7];
          nxt_sdo_oe = 1'b1;
          nxt_st = S_REPLY;
        end
        S_REPLY: begin
          if (sck_rise) begin
            nxt_rep = {rep_ff[6:0], 1'b0};
            nxt_sdo = rep_ff[6];
            nxt_cnt = cnt_ff + 6'h1;
            if (cnt_ff == 6'(REPLY_BITS - 1)) begin
              nxt_sdo_oe = 1'b0;
              nxt_cnt = 6'h0;
              nxt_st = S_SHIFT;
            end
          end
        end
        default: nxt_st = S_SHIFT;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= S_SHIFT;
      sh_ff <= 32'h0;
      cnt_ff <= 6'h0;
      rep_ff <= 8'h0;
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
      cwr_ff <= 1'b0;
      caddr_ff <= 16'h0;
      cwd_ff <= 8'h0;
      cust_ff <= {32{UNPROG_BYTE}};
      cfg1_ff <= UNPROG_BYTE;
      cfg2_ff <= UNPROG_BYTE;
      lock_ff <= 2'h3;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      cnt_ff <= nxt_cnt;
      rep_ff <= nxt_rep;
      sdo_ff <= nxt_sdo;
      sdo_oe_ff <= nxt_sdo_oe;
      cwr_ff <= nxt_cwr;
      caddr_ff <= nxt_caddr;
      cwd_ff <= nxt_cwd;
      cust_ff <= nxt_cust;
      cfg1_ff <= nxt_cfg1;
      cfg2_ff <= nxt_cfg2;
      lock_ff <= nxt_lock;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu read port and power-up configuration
  logic [7:0] rd_ff, nxt_rd;
  logic rv_ff, nxt_rv;
  logic loaded_ff, nxt_loaded;
  otpcfg_applied_t app_ff, nxt_app;

  always_comb begin
    nxt_rd = rd_ff;
    nxt_rv = 1'b0;
    if (code_req_i.rd) begin
      nxt_rv = 1'b1;
      if (code_req_i.fetch && in_cust(code_req_i.addr)) nxt_rd = UNPROG_BYTE;
      else nxt_rd = otp_read(code_req_i.addr, cust_ff, cfg1_ff, cfg2_ff);
    end else if (xdata_req_i.rd) begin
      nxt_rv = 1'b1;
      if (xdata_req_i.addr == CFG1_ADDR) nxt_rd = cfg1_ff;
      else if (xdata_req_i.addr == CFG2_ADDR) nxt_rd = cfg2_ff;
      else nxt_rd = UNPROG_BYTE;
    end
    // latched once after reset release; later otp changes wait for next power up
    nxt_loaded = 1'b1;
    nxt_app = app_ff;
    if (!loaded_ff) begin
      nxt_app.watchdog_fuse = cfg1_ff[WDOG_POS];
      nxt_app.reset_pin_fuse = cfg1_ff[RSTPIN_POS];
      nxt_app.port_reset_level = cfg1_ff[PRL_POS];
      nxt_app.brownout_level_fuse = cfg1_ff[BOV_POS];
      nxt_app.cycle_divider_fuse = cfg1_ff[CDIV_POS];
      nxt_app.osc_select_field = cfg1_ff[OSC_MSB:OSC_LSB];
      nxt_app.config_byte_two = cfg2_ff;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_ff <= 8'h0;
      rv_ff <= 1'b0;
      loaded_ff <= 1'b0;
      app_ff <= {5'h1F, OSC_EXT_CLOCK, UNPROG_BYTE};
    end else begin
      rd_ff <= nxt_rd;
      rv_ff <= nxt_rv;
      loaded_ff <= nxt_loaded;
      app_ff <= nxt_app;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flops
  logic pa_ff, va_ff;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pa_ff <= 1'b1;
      va_ff <= 1'b1;
    end else begin
      pa_ff <= prog_ok;
      va_ff <= verify_ok;
    end
  end

  assign ser_data_o = sdo_ff;
  assign ser_data_oe_o = sdo_oe_ff;
  assign rd_data_o = rd_ff;
  assign rd_valid_o = rv_ff;
  assign code_wr_o = cwr_ff;
  assign code_addr_o = caddr_ff;
  assign code_wdata_o = cwd_ff;
  assign prog_allowed_o = pa_ff;
  assign verify_allowed_o = va_ff;
  assign cfg_valid_o = loaded_ff;
  assign applied_o = app_ff;

endmodule : otpcfg_top

/* otpcfg_asserts.sv */
// checker: port assertions of the otp config block
module otpcfg_asserts
  import otpcfg_pkg::*;
#(
  parameter logic [7:0] SIG_BYTE_0 = 8'h00 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire otpcfg_req_t code_req_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic code_wr_o,
  input wire logic [15:0] code_addr_o,
  input wire logic prog_allowed_o,
  input wire logic verify_allowed_o,
  input wire logic cfg_valid_o,
  input wire otpcfg_applied_t applied_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  sequence s_rd(logic f, logic [15:0] lo, logic [15:0] hi);
    code_req_i.rd && code_req_i.fetch == f && code_req_i.addr >= lo && code_req_i.addr <= hi;
  endsequence
  property p_answer;
    code_req_i.rd |=> rd_valid_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_sig;
    s_rd(1'b0, SIG_ADDR_0, SIG_ADDR_0) |=> rd_data_o == SIG_BYTE_0;
  endproperty
  a_sig: assert property (p_sig) else $error("bad signature");
  property p_fetch;
    s_rd(1'b1, CUST_BASE, CUST_LAST) |=> rd_data_o == UNPROG_BYTE;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch served");
  property p_lock;
    !prog_allowed_o |-> !code_wr_o;
  endproperty
  a_lock: assert property (p_lock) else $error("write while locked");
  property p_both;
    !verify_allowed_o |-> !prog_allowed_o;
  endproperty
  a_both: assert property (p_both) else $error("program open");
  property p_mono;
    !prog_allowed_o |=> !prog_allowed_o;
  endproperty
  a_mono: assert property (p_mono) else $error("lock reopened");
  property p_cfg;
    cfg_valid_o && $past(cfg_valid_o) |-> $stable(applied_o);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config moved");
  property p_wr;
    code_wr_o |-> code_addr_o < CODE_SIZE ##1 !code_wr_o;
  endproperty
  a_wr: assert property (p_wr) else $error("bad write");
endmodule : otpcfg_asserts
bind otpcfg_top otpcfg_asserts #(.SIG_BYTE_0(SIG_BYTE_0)) u_otpcfg_asserts (.clk_i, .rst_b_i, .code_req_i,
  .rd_data_o, .rd_valid_o, .code_wr_o, .code_addr_o, .prog_allowed_o, .verify_allowed_o, .cfg_valid_o, .applied_o);

/* otpcfg_prog.sv */
// partner: programmer model on the two-pin serial link
module otpcfg_prog
  import otpcfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic pin_i,
  output logic ser_clk_o,
  output logic drv_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ser_clk_o = 1'b0;
    drv_o = 1'b0;
  end
  // six clocks a phase, margin over the four-clock minimum
  task automatic half();
    repeat (6) @(negedge clk_i);
  endtask : half
  task automatic frame(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, output logic [7:0] rep);
    logic [31:0] sh;
    sh = {c, a, d};
    for (int i = 39; i >= 0; i--) begin
      if (i > 7) drv_o = sh[i - 8];
      // released pin shows the inverse, not a stale bit
      if (i == 7) drv_o = ~drv_o;
      half();
      if (i < 8) rep[i] = pin_i;
      ser_clk_o = 1'b1;
      half();
      ser_clk_o = 1'b0;
      if (i == 8 && c != CMD_READ) break;
    end
    half();
  endtask : frame
endmodule : otpcfg_prog

/* otpcfg_tb.sv */
// testbench: cpu reads and serial programming against a model
module testbench
  import otpcfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] S0 = 8'h61; // arbitrary value
  localparam logic [7:0] S1 = 8'h4E; // arbitrary value
  localparam logic [7:0] S2 = 8'h73; // arbitrary value
  logic clk_i = 1'b0, rst_b_i = 1'b0, prog_mode_i = 1'b0, ser_clk_i, drv, ser_data_o, ser_data_oe_o;
  logic rd_valid_o, code_wr_o, prog_allowed_o, verify_allowed_o, cfg_valid_o;
  logic [7:0] rd_data_o, code_wdata_o, r, code_rdata_i = 8'hFF;
  logic [15:0] code_addr_o, a;
  logic [31:0] seed = 32'h2;
  otpcfg_req_t code_req_i = '0, xdata_req_i = '0;
  otpcfg_applied_t applied_o;
  wire logic ser_data_i = ser_data_oe_o ? ser_data_o : drv;
  int mismatches = 0, check_count = 0, nwr = 0, cfg1 = 255, o, d, cd;
  int cust[32] = '{default: 255};
  otpcfg_top #(.SIG_BYTE_0(S0), .SIG_BYTE_1(S1), .SIG_BYTE_2(S2)) u_otpcfg_top (.clk_i, .rst_b_i, .prog_mode_i,
    .ser_clk_i, .ser_data_i, .ser_data_o,
    .ser_data_oe_o, .code_req_i, .xdata_req_i, .rd_data_o, .rd_valid_o, .code_wr_o, .code_addr_o, .code_wdata_o,
    .code_rdata_i, .prog_allowed_o, .verify_allowed_o, .cfg_valid_o, .applied_o);
  otpcfg_prog u_otpcfg_prog (.clk_i, .pin_i(ser_data_i), .ser_clk_o(ser_clk_i), .drv_o(drv));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // one-byte code array: only one main address is programmed
  always @(negedge clk_i) begin
    if (code_wr_o === 1'b1) begin
      nwr++;
      chk(code_addr_o, a);
      code_rdata_i <= code_wdata_o;
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task automatic cpu(input bit x, input logic f, input logic [15:0] ad, input logic [7:0] e);
    @(negedge clk_i);
    if (x) xdata_req_i = '{1'b1, f, ad};
    else code_req_i = '{1'b1, f, ad};
    @(negedge clk_i);
    code_req_i.rd = 1'b0;
    xdata_req_i.rd = 1'b0;
    chk({rd_valid_o, rd_data_o}, {1'b1, e});
  endtask : cpu
  task automatic fr(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] dt);
    u_otpcfg_prog.frame(c, ad, dt, r);
  endtask : fr
  initial begin
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    prog_mode_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk(applied_o, 16'hFFFF);
    chk({prog_allowed_o, verify_allowed_o, cfg_valid_o}, 16'h7);
    cpu(1'b0, 1'b0, SIG_ADDR_0, S0);
    cpu(1'b0, 1'b0, SIG_ADDR_1, S1);
    cpu(1'b0, 1'b1, SIG_ADDR_2, S2);
    cpu(1'b1, 1'b0, SIG_ADDR_0, UNPROG_BYTE);
    cpu(1'b1, 1'b0, CFG2_ADDR, UNPROG_BYTE);
    for (int k = 0; k < 3; k++) begin
      o = k ? xs() % 32 : 31;
      d = xs() % 256;
      fr(CMD_WRITE, CUST_BASE + 16'(o), 8'(d));
      cust[o] &= d;
      cpu(1'b0, 1'b0, CUST_BASE + 16'(o), 8'(cust[o]));
      cpu(1'b0, 1'b1, CUST_BASE + 16'(o), UNPROG_BYTE);
    end
    // cut frame: dropping the mode pin mid-frame must discard the write
    fork
      fr(CMD_WRITE, CUST_BASE, 8'h00);
      begin
        repeat (100) @(negedge clk_i);
        prog_mode_i = 1'b0;
      end
    join
    repeat (4) @(negedge clk_i);
    prog_mode_i = 1'b1;
    repeat (4) @(negedge clk_i);
    cpu(1'b0, 1'b0, CUST_BASE, 8'(cust[0]));
    a = 16'(xs()) & 16'h0FFF;
    cd = xs() % 256;
    fr(CMD_WRITE, a, 8'(cd));
    fr(CMD_READ, a, 8'h00);
    chk({ser_data_oe_o, r}, {1'b0, 8'(cd)});
    d = xs() & 32'hDF;
    fr(CMD_WRITE, CFG1_ADDR, 8'(d));
    cfg1 &= d;
    cpu(1'b1, 1'b0, CFG1_ADDR, 8'(cfg1));
    chk(applied_o, 16'hFFFF);
    fr(CMD_LOCK, 16'h0000, 8'hFE);
    fr(CMD_WRITE, a, 8'h00);
    fr(CMD_READ, a, 8'h00);
    chk({nwr[7:0], r}, {8'h01, 8'(cd)});
    chk({prog_allowed_o, verify_allowed_o}, 16'h1);
    // lock two after lock one; the engine also takes lock two alone
    fr(CMD_LOCK, 16'h0000, 8'hFC);
    fr(CMD_READ, a, 8'h00);
    chk({prog_allowed_o, verify_allowed_o, r}, {2'h0, REFUSED_BYTE});
    results();
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    mismatches++;
    results();
  end
endmodule : testbench
